// ### pkg/cgm_map.vh
// register offsets, field positions, reset values and timing counts for the clock generator
`ifndef CGM_MAP_VH
`define CGM_MAP_VH
`define CGM_OFF_CTRL1 8'h00
`define CGM_OFF_CTRL2 8'h04
`define CGM_OFF_CTRL3 8'h08
`define CGM_OFF_CTRL4 8'h0c
`define CGM_OFF_STAT 8'h10
`define CGM_OFF_TRIMC 8'h14
`define CGM_OFF_TCNT 8'h18
`define CGM_OFF_TRIMV 8'h1c
`define CGM_OFF_FACT 8'h20
// ctrl1 fields
`define CGM_C1_INTERNAL_REF_CLOCK_ENABLE 1
`define CGM_C1_REFSEL 2
`define CGM_C1_DIV_LO 3
`define CGM_C1_CSS_LO 6
// ctrl2 fields
`define CGM_C2_FSSEL 0
`define CGM_C2_LP 1
`define CGM_C2_EXTREQ 2
// ctrl4 fields
`define CGM_C4_DRS_LO 5
`define CGM_C4_TUNING_32K_BIT 7
// trim control fields
`define CGM_TC_OSCSEL 5
`define CGM_TC_FAIL 6
`define CGM_TC_EN 7
// status fields
`define CGM_ST_EXTRDY 1
`define CGM_ST_CSST_LO 2
`define CGM_ST_REFST 4
`define CGM_ST_PLLOFF 5
`define CGM_ST_FSST 0
`define CGM_CTRL1_RST 8'h04
`define CGM_CSS_FLL 2'b00
`define CGM_CSS_INT 2'b01
`define CGM_CSS_EXT 2'b10
`define CGM_FAST_DIV 8'h80
`define CGM_TRIM_RST 9'h100
`define CGM_STAT_RST 8'h00
`define CGM_SW_NS 20
`define CGM_SW_CYC ((`CGM_SW_NS + 9) / 10)
`endif

// ### core/cgm_div.v
// divider that turns oscillator ticks into one measurement gate pulse
module cgm_div #(
  parameter W = 8
) (
  input wire core_clk,
  input wire nrst,
  input wire clr,
  input wire tick,
  input wire [W-1:0] ratio,
  output reg gate_done
);
  reg [W-1:0] cnt_reg;
  always @(posedge core_clk) begin
    if (!nrst || clr) begin
      cnt_reg <= {W{1'b0}};
      gate_done <= 1'b0;
    end else begin
      gate_done <= 1'b0;
      if (tick) begin
        if (cnt_reg + 1'b1 >= ratio) begin
          cnt_reg <= {W{1'b0}};
          gate_done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 1'b1;
        end
      end
    end
  end
endmodule

// ### core/cgm_sync.v
// two-flop synchroniser for signals that arrive from other clocks
module cgm_sync #(
  parameter W = 1
) (
  input wire core_clk,
  input wire nrst,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg;
  always @(posedge core_clk) begin
    if (!nrst) begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// ### core/cgm_top.v
// clock generator mode control and internal reference auto-trim machine
// Operation
// RL1: trim select picks slow or fast oscillator
// RL2: fast oscillator divided by 128 for trim
// RL3: trim enable starts run, self-clears
// RL4: control or trim writes, stop abort trim; ctrl2 writes do not abort here
// RL5: abort sets trim fail flag
// RL6: software uses external clock, bus 8-16 MHz
// RL7: successive approximation from trim msb
// RL8: oscillator gate counts bus clocks, compare
// RL9: clear or keep bit, all bits
// RL10: software loads expected count times 21
// RL11: reset into fll engaged internal mode
// RL12: software leaves reset mode via three modes
// RL13: fll keeps running in bypassed external
// RL14: software sets divider for 31.25-39.0625 kHz
// RL15: dco range gives 640 to 2560
// RL16: 32k tuning gives 732 to 2929
// RL17: dco range writes ignored in low power
// RL18: software polls status after each switch
// RL19: source select codes mirrored in status
// RL20: fast/slow select routes internal ref
// RL21: output clock source per mode
// RL22: software avoids 32k tuning internally
// RL23: unavailable source keeps previous selection
// RL24: low power disables fll in bypass
// RL25: clean run keeps result, no fail
//
// Added by the designer: the address map and the AXI4-Lite register port.
`include "cgm_map.vh"
module cgm_top #(
  parameter TRIM_W = 9,
  parameter CNT_W = 16
) (
  input wire core_clk,
  input wire nrst,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire slow_osc_clk,
  input wire fast_osc_clk,
  input wire ext_osc_ready,
  input wire stop_mode,
  output reg [1:0] output_clock_sel,
  output reg fll_ref_external,
  output reg fll_enable,
  output reg [11:0] fll_factor,
  output reg [2:0] reference_divider,
  output reg fast_slow_osc_select,
  output reg internal_ref_clock_enable,
  output reg external_osc_request,
  output reg [TRIM_W-1:0] slow_trim,
  output reg [TRIM_W-1:0] fast_trim
);
  // factor lookup for the output register; the readback returns that register
  function [11:0] fll_mult;
    input [1:0] rng;
    input tune32;
    begin
      case ({tune32, rng})
        3'h0: fll_mult = 12'd640;
        3'h1: fll_mult = 12'd1280;
        3'h2: fll_mult = 12'd1920;
        3'h3: fll_mult = 12'd2560;
        3'h4: fll_mult = 12'd732;
        3'h5: fll_mult = 12'd1464;
        3'h6: fll_mult = 12'd2197;
        default: fll_mult = 12'd2929;
      endcase
    end
  endfunction
  localparam S_IDLE = 2'd0;
  localparam S_MEAS = 2'd1;
  localparam S_DEC = 2'd2;
  localparam S_SYNC = 2'd3;
  reg [7:0] ctrl1_reg, ctrl2_reg, ctrl4_reg, trimc_reg;
  reg [15:0] tcnt_reg;
  reg [1:0] csst_reg;
  reg refst_reg, fsst_reg;
  reg [1:0] st_reg;
  reg [TRIM_W-1:0] sar_reg;
  reg [3:0] bit_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg [1:0] osc_hist_reg;
  reg [31:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  reg aw_have_reg, w_have_reg;
  wire slow_s, fast_s, ext_rdy_s, stop_s, gate_done;
  cgm_sync #(.W(4)) u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .d({slow_osc_clk, fast_osc_clk, ext_osc_ready, stop_mode}),
    .q({slow_s, fast_s, ext_rdy_s, stop_s})
  );
  // RL1: oscillator under trim
  wire trim_fast = trimc_reg[`CGM_TC_OSCSEL];
  wire osc_s = trim_fast ? fast_s : slow_s;
  wire osc_rise = osc_hist_reg == 2'b01;
  wire running = st_reg != S_IDLE;
  wire drop_bit = st_reg == S_DEC && cnt_reg > tcnt_reg;
  wire [TRIM_W-1:0] sar_now = drop_bit ?
                              sar_reg & ~({{(TRIM_W-1){1'b0}}, 1'b1} << bit_reg) : sar_reg;
  // RL2: fast oscillator passes a divide-by-128 stage
  cgm_div #(.W(8)) u_div (
    .core_clk(core_clk),
    .nrst(nrst),
    .clr(st_reg != S_MEAS),
    .tick(osc_rise),
    .ratio(trim_fast ? `CGM_FAST_DIV : 8'h01),
    .gate_done(gate_done)
  );
  // write channel: address and data may come in either order
  wire do_wr = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire [7:0] wa = awaddr_reg[7:0];
  wire wr_c1 = do_wr && wa == `CGM_OFF_CTRL1 && wstrb_reg[0];
  wire wr_c2 = do_wr && wa == `CGM_OFF_CTRL2 && wstrb_reg[0];
  wire wr_c3 = do_wr && wa == `CGM_OFF_CTRL3 && wstrb_reg[0];
  wire wr_c4 = do_wr && wa == `CGM_OFF_CTRL4 && wstrb_reg[0];
  wire wr_tc = do_wr && wa == `CGM_OFF_TRIMC && wstrb_reg[0];
  wire wr_cv = do_wr && wa == `CGM_OFF_TCNT;
  wire wr_tv = do_wr && wa == `CGM_OFF_TRIMV;
  wire mapped_w = wa <= `CGM_OFF_FACT && wa[1:0] == 2'b00;
  // RL4: abort sources
  wire abort = running && (wr_c1 || wr_c3 || wr_c4 || wr_tc || stop_s);
  always @(posedge core_clk) begin
    if (!nrst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 32'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_have_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped_w ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end
  // control registers
  always @(posedge core_clk) begin
    if (!nrst) begin
      // RL11: reset into fll engaged internal
      ctrl1_reg <= `CGM_CTRL1_RST;
      ctrl2_reg <= 8'h00;
      ctrl4_reg <= 8'h00;
      tcnt_reg <= 16'h0;
    end else begin
      if (wr_c1)
        ctrl1_reg <= wdata_reg[7:0];
      if (wr_c2)
        ctrl2_reg <= wdata_reg[7:0];
      if (wr_c4) begin
        ctrl4_reg[`CGM_C4_TUNING_32K_BIT] <= wdata_reg[`CGM_C4_TUNING_32K_BIT];
        // RL17: range frozen while low power is set
        if (!ctrl2_reg[`CGM_C2_LP])
          ctrl4_reg[`CGM_C4_DRS_LO+1:`CGM_C4_DRS_LO] <=
            wdata_reg[`CGM_C4_DRS_LO+1:`CGM_C4_DRS_LO];
      end
      if (wr_cv && wstrb_reg[0])
        tcnt_reg[7:0] <= wdata_reg[7:0];
      if (wr_cv && wstrb_reg[1])
        tcnt_reg[15:8] <= wdata_reg[15:8];
    end
  end
  // trim control and the successive approximation machine
  always @(posedge core_clk) begin
    if (!nrst) begin
      trimc_reg <= 8'h00;
      st_reg <= S_IDLE;
      sar_reg <= {TRIM_W{1'b0}};
      bit_reg <= 4'h0;
      cnt_reg <= {CNT_W{1'b0}};
      osc_hist_reg <= 2'b00;
      slow_trim <= `CGM_TRIM_RST;
      fast_trim <= `CGM_TRIM_RST;
    end else begin
      osc_hist_reg <= {osc_hist_reg[0], osc_s};
      if (wr_tv && !running) begin
        if (trim_fast)
          fast_trim <= wdata_reg[TRIM_W-1:0];
        else
          slow_trim <= wdata_reg[TRIM_W-1:0];
      end
      if (abort) begin
        // RL5: abort raises the fail flag
        trimc_reg[`CGM_TC_EN] <= 1'b0;
        trimc_reg[`CGM_TC_FAIL] <= 1'b1;
        if (wr_tc)
          trimc_reg[`CGM_TC_OSCSEL] <= wdata_reg[`CGM_TC_OSCSEL];
        st_reg <= S_IDLE;
      end else begin
        if (wr_tc) begin
          trimc_reg[`CGM_TC_OSCSEL] <= wdata_reg[`CGM_TC_OSCSEL];
          // fail flag clears on writing one
          if (wdata_reg[`CGM_TC_FAIL])
            trimc_reg[`CGM_TC_FAIL] <= 1'b0;
          // RL3: start run
          if (wdata_reg[`CGM_TC_EN]) begin
            trimc_reg[`CGM_TC_EN] <= 1'b1;
            st_reg <= S_SYNC;
            // RL7: begin with msb set
            sar_reg <= {1'b1, {(TRIM_W-1){1'b0}}};
            bit_reg <= TRIM_W[3:0] - 4'h1;
            cnt_reg <= {CNT_W{1'b0}};
          end
        end
        case (st_reg)
          S_IDLE: begin
          end
          // gate opens on an oscillator rise so each count spans whole periods
          S_SYNC:
            if (osc_rise)
              st_reg <= S_MEAS;
          S_MEAS: begin
            // RL8: bus clocks counted during the gate
            if (gate_done)
              st_reg <= S_DEC;
            else if (cnt_reg != {CNT_W{1'b1}})
              cnt_reg <= cnt_reg + 1'b1;
          end
          S_DEC: begin
            // RL9: longer period means too slow a clock, so drop the bit
            if (cnt_reg > tcnt_reg)
              sar_reg[bit_reg] <= 1'b0;
            cnt_reg <= {CNT_W{1'b0}};
            if (bit_reg == 4'h0) begin
              // RL25: clean finish keeps result
              st_reg <= S_IDLE;
              trimc_reg[`CGM_TC_EN] <= 1'b0;
            end else begin
              bit_reg <= bit_reg - 4'h1;
              sar_reg[bit_reg - 4'h1] <= 1'b1;
              st_reg <= S_SYNC;
            end
          end
          default: st_reg <= S_IDLE;
        endcase
      end
      // trial value drives the oscillator under trim while running
      if (running && !abort) begin
        if (trim_fast)
          fast_trim <= sar_now;
        else
          slow_trim <= sar_now;
      end
    end
  end
  // status and outputs
  wire [1:0] css = ctrl1_reg[`CGM_C1_CSS_LO+1:`CGM_C1_CSS_LO];
  wire ref_int = ctrl1_reg[`CGM_C1_REFSEL];
  wire lp = ctrl2_reg[`CGM_C2_LP];
  // RL23: external source needs a ready oscillator, code 11 never available
  wire css_ok = css == `CGM_CSS_FLL || css == `CGM_CSS_INT ||
                (css == `CGM_CSS_EXT && ext_rdy_s);
  wire bypass = csst_reg != `CGM_CSS_FLL;

  always @(posedge core_clk) begin
    if (!nrst) begin
      csst_reg <= `CGM_CSS_FLL;
      refst_reg <= 1'b1;
      fsst_reg <= 1'b0;
      output_clock_sel <= `CGM_CSS_FLL;
      fll_ref_external <= 1'b0;
      fll_enable <= 1'b1;
      fll_factor <= 12'd640;
      reference_divider <= 3'b000;
      fast_slow_osc_select <= 1'b0;
      internal_ref_clock_enable <= 1'b0;
      external_osc_request <= 1'b0;
    end else begin
      // RL19: status follows a completed switch
      if (css_ok)
        csst_reg <= css;
      refst_reg <= ref_int || !ext_rdy_s;
      fsst_reg <= ctrl2_reg[`CGM_C2_FSSEL];
      // RL21: output source per mode
      output_clock_sel <= csst_reg;
      fll_ref_external <= !refst_reg;
      // RL13: fll runs in bypass unless low power or stop mode
      // RL24: low power stops fll in bypass
      fll_enable <= !(bypass && lp) && !stop_s;
      // RL15: factor from range and tuning
      // RL16: tuned factors
      fll_factor <= fll_mult(ctrl4_reg[`CGM_C4_DRS_LO+1:`CGM_C4_DRS_LO],
                             ctrl4_reg[`CGM_C4_TUNING_32K_BIT]);
      reference_divider <= ctrl1_reg[`CGM_C1_DIV_LO+2:`CGM_C1_DIV_LO];
      // RL20: internal ref routed by fast/slow select
      fast_slow_osc_select <= ctrl2_reg[`CGM_C2_FSSEL];
      internal_ref_clock_enable <= ctrl1_reg[`CGM_C1_INTERNAL_REF_CLOCK_ENABLE];
      external_osc_request <= ctrl2_reg[`CGM_C2_EXTREQ];
    end
  end
  // read channel, one cycle after the address is taken
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0;
    case (s_axi_araddr[7:0])
      `CGM_OFF_CTRL1: rd_mux = {24'h0, ctrl1_reg};
      `CGM_OFF_CTRL2: rd_mux = {24'h0, ctrl2_reg};
      `CGM_OFF_CTRL4: rd_mux = {24'h0, ctrl4_reg};
      `CGM_OFF_STAT: rd_mux = {26'h0, !fll_enable, refst_reg, csst_reg,
                               ext_rdy_s, fsst_reg};
      `CGM_OFF_TRIMC: rd_mux = {24'h0, trimc_reg};
      `CGM_OFF_TCNT: rd_mux = {16'h0, tcnt_reg};
      `CGM_OFF_TRIMV: rd_mux = {{(32-TRIM_W){1'b0}}, trim_fast ? fast_trim : slow_trim};
      `CGM_OFF_FACT: rd_mux = {20'h0, fll_factor};
      default: rd_mux = 32'h0;
    endcase
  end
  wire rd_ok = s_axi_araddr[7:0] <= `CGM_OFF_FACT && s_axi_araddr[1:0] == 2'b00 &&
               s_axi_araddr[31:8] == 24'h0;
  always @(posedge core_clk) begin
    if (!nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_ok ? rd_mux : 32'h0;
        s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// ### sim/cgm_top_chk.sv
// port-level assertions for the clock generator block
module cgm_top_chk #(
  parameter TRIM_W = 9,
  parameter CNT_W = 16
) (
  input wire core_clk,
  input wire nrst,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire stop_mode,
  input wire [1:0] output_clock_sel,
  input wire fll_ref_external,
  input wire fll_enable,
  input wire [11:0] fll_factor,
  input wire [TRIM_W-1:0] slow_trim,
  input wire [TRIM_W-1:0] fast_trim
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_rst_mode;
    $rose(nrst) |-> output_clock_sel == 2'b00 && fll_enable && !fll_ref_external
      && fll_factor == 12'd640;
  endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("mode after reset wrong");
  property p_rst_trim;
    $rose(nrst) |-> slow_trim == 9'h100 && fast_trim == 9'h100;
  endproperty
  a_rst_trim: assert property (p_rst_trim) else $error("trim start value wrong");
  property p_factor;
    fll_factor inside {12'd640, 12'd1280, 12'd1920, 12'd2560, 12'd732, 12'd1464,
      12'd2197, 12'd2929};
  endproperty
  a_factor: assert property (p_factor) else $error("illegal fll factor");
  property p_src;
    output_clock_sel != 2'b11;
  endproperty
  a_src: assert property (p_src) else $error("unknown source selected");
  property p_stop;
    stop_mode [*5] |-> !fll_enable;
  endproperty
  a_stop: assert property (p_stop) else $error("fll kept running in stop");
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write response late");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read response late");
  property p_b_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken during response");
endmodule

bind cgm_top cgm_top_chk #(.TRIM_W(TRIM_W), .CNT_W(CNT_W)) cgm_top_chk_i (.core_clk, .nrst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .stop_mode, .output_clock_sel,
  .fll_ref_external, .fll_enable, .fll_factor, .slow_trim, .fast_trim);

// ### sim/cgm_top_tb_top.sv
// self-checking bench for clock mode control and auto-trim
`include "cgm_map.vh"
module cgm_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic slow_osc_clk, fast_osc_clk, ext_osc_ready, stop_mode;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic fll_ref_external, fll_enable, fast_slow_osc_select, internal_ref_clock_enable;
  logic external_osc_request;
  logic [1:0] s_axi_bresp, s_axi_rresp, output_clock_sel, rsp;
  logic [11:0] fll_factor;
  logic [2:0] reference_divider, fcnt;
  logic [8:0] slow_trim, fast_trim;
  logic [9:0] scnt;
  int n_errors, checked, cyc;

  cgm_top cgm_top_i (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .slow_osc_clk, .fast_osc_clk,
    .ext_osc_ready, .stop_mode, .output_clock_sel, .fll_ref_external, .fll_enable,
    .fll_factor, .reference_divider, .fast_slow_osc_select, .internal_ref_clock_enable,
    .external_osc_request, .slow_trim, .fast_trim);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // slow period tracks its trim (2*trim+8 cycles) so the search has a real target
  always @(posedge core_clk) begin
    fcnt <= fcnt + 3'h1;
    fast_osc_clk <= fcnt[2];
    if (scnt >= {1'b0, slow_trim} + 10'h3) begin
      scnt <= 10'h0;
      slow_osc_clk <= ~slow_osc_clk;
    end else begin
      scnt <= scnt + 10'h1;
    end
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors = n_errors + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v, int n);
    int i;
    for (i = 0; i < n; i++) begin
      axi_rd(a);
      if ((rd & m) === v) break;
    end
    chk(rd & m, v);
  endtask

  task automatic t_reset();
    chk({16'h0, output_clock_sel, fll_ref_external, fll_enable, fll_factor}, 32'h1280);
    axi_rd(`CGM_OFF_CTRL1);
    chk(rd, 32'h4);
    axi_rd(8'h24);
    chk({rd[29:0], rsp}, 32'h2);
    $display("test reset done");
  endtask

  task automatic t_factor();
    int i;
    logic [11:0] f [8] = '{640, 1280, 1920, 2560, 732, 1464, 2197, 2929};
    for (i = 0; i < 8; i++) begin
      axi_wr(`CGM_OFF_CTRL4, {24'h0, i[2], i[1:0], 5'h0});
      axi_rd(`CGM_OFF_CTRL4);
      chk({20'h0, fll_factor}, {20'h0, f[i]});
    end
    axi_wr(`CGM_OFF_CTRL4, 32'h0);
    $display("test factor done");
  endtask

  task automatic t_modes();
    // leave reset mode through bypassed internal
    axi_wr(`CGM_OFF_CTRL1, 32'h44);
    poll(`CGM_OFF_STAT, 32'hc, 32'h4, 40);
    chk({30'h0, output_clock_sel}, 32'h1);
    axi_wr(`CGM_OFF_CTRL4, 32'h20);
    axi_wr(`CGM_OFF_CTRL2, 32'h2);
    axi_rd(`CGM_OFF_CTRL2);
    chk({31'h0, fll_enable}, 32'h0);
    axi_wr(`CGM_OFF_CTRL4, 32'h60);
    axi_rd(`CGM_OFF_CTRL4);
    chk({20'h0, fll_factor}, 32'd1280);
    axi_wr(`CGM_OFF_CTRL2, 32'h4);
    axi_wr(`CGM_OFF_CTRL4, 32'h0);
    axi_rd(`CGM_OFF_CTRL4);
    chk({19'h0, fll_enable, fll_factor}, {19'h0, 1'b1, 12'd640});
    axi_wr(`CGM_OFF_CTRL1, 32'h90);
    repeat (8) axi_rd(`CGM_OFF_STAT);
    chk({rd[31:4], rd[1:0], output_clock_sel}, 32'h11);
    ext_osc_ready <= 1'b1;
    poll(`CGM_OFF_STAT, 32'hc, 32'h8, 40);
    chk({25'h0, output_clock_sel, fll_ref_external, fll_enable, reference_divider},
      {25'h0, 2'b10, 1'b1, 1'b1, 3'b010});
    chk({29'h0, fast_slow_osc_select, internal_ref_clock_enable, external_osc_request},
      32'h1);
    axi_wr(`CGM_OFF_CTRL2, 32'h5);
    poll(`CGM_OFF_STAT, 32'h1, 32'h1, 40);
    chk({29'h0, fast_slow_osc_select, internal_ref_clock_enable, external_osc_request},
      32'h5);
    $display("test modes done");
  endtask

  // both runs are made with the system clock on the external reference
  task automatic t_trim();
    axi_wr(`CGM_OFF_TCNT, 32'd339);
    axi_wr(`CGM_OFF_TRIMC, 32'h80);
    axi_rd(`CGM_OFF_TRIMC);
    chk(rd & 32'he0, 32'h80);
    poll(`CGM_OFF_TRIMC, 32'h80, 32'h0, 9000);
    chk(rd & 32'h40, 32'h0);
    chk({23'h0, slow_trim}, 32'd165);
    axi_rd(`CGM_OFF_TRIMV);
    chk(rd, 32'd165);
    axi_wr(`CGM_OFF_TCNT, 32'd960);
    axi_wr(`CGM_OFF_TRIMC, 32'ha0);
    poll(`CGM_OFF_TRIMC, 32'h80, 32'h0, 9000);
    chk(rd & 32'h60, 32'h20);
    chk({23'h0, fast_trim}, 32'h0);
    $display("test trim done");
  endtask

  task automatic t_abort();
    int i;
    logic [7:0] a [4] = '{`CGM_OFF_CTRL1, `CGM_OFF_CTRL3, `CGM_OFF_CTRL4, `CGM_OFF_TRIMC};
    logic [31:0] v [4] = '{32'h90, 32'h0, 32'h0, 32'h20};
    for (i = 0; i < 5; i++) begin
      axi_wr(`CGM_OFF_TRIMC, 32'hc0);
      axi_rd(`CGM_OFF_TRIMC);
      chk(rd & 32'hc0, 32'h80);
      if (i < 4) begin
        axi_wr(a[i], v[i]);
      end else begin
        stop_mode <= 1'b1;
        repeat (6) @(posedge core_clk);
        stop_mode <= 1'b0;
      end
      axi_rd(`CGM_OFF_TRIMC);
      chk(rd & 32'hc0, 32'h40);
    end
    $display("test abort done");
  endtask

  initial begin
    n_errors = 0;
    checked = 0;
    cyc = 0;
    fcnt = 3'h0;
    scnt = 10'h0;
    nrst = 1'b0;
    {slow_osc_clk, fast_osc_clk, ext_osc_ready, stop_mode} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    t_reset();
    // tuning bit only exercised once an external mode is set
    t_modes();
    t_factor();
    t_trim();
    t_abort();
    complete_run();
  end
endmodule
